// ==== cgt_pkg.sv ====
package cgt_pkg;

   localparam int unsigned ADDR_W = 5;

   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_SRC_CTRL  = 3'h0;
   localparam logic [2:0] IDX_DIV_CTRL  = 3'h1;
   localparam logic [2:0] IDX_COARSE    = 3'h2;
   localparam logic [2:0] IDX_FINE_CTRL = 3'h3;
   localparam logic [2:0] IDX_STATUS    = 3'h4;

   // Field positions
   localparam int unsigned SRC_SEL_LSB     = 6;
   localparam int unsigned DIV_LSB         = 5;
   localparam int unsigned PWR_DOWN_BIT    = 4;
   localparam int unsigned LOL_IRQ_EN_BIT  = 7;
   localparam int unsigned MON_EN_BIT      = 5;
   localparam int unsigned FINE_TRIM_BIT   = 0;
   localparam int unsigned LOL_FLAG_BIT    = 7;

   // Values after reset, and the wrap value of the divider counter
   localparam logic [2:0] DIV_RESET       = 3'h1;
   localparam logic [7:0] COARSE_RESET    = 8'h00;
   localparam logic       FINE_RESET      = 1'h0;
   localparam logic [6:0] DIV_COUNT_WRAP  = 7'h7F;

   typedef enum logic [1:0] {
      CGT_SRC_LOOP = 2'h0,
      CGT_SRC_INT  = 2'h1,
      CGT_SRC_EXT  = 2'h2,
      CGT_SRC_RSV  = 2'h3
   } cgt_src_t;

   typedef enum logic [1:0] {
      CGT_ST_LOAD = 2'b01,
      CGT_ST_RUN  = 2'b10
   } cgt_state_t;

   // Word index from a byte address; misaligned addresses never hit
   function automatic logic cgt_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [2:0]        idx);
      cgt_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
   endfunction : cgt_hit

endpackage : cgt_pkg

// ==== cgt_clk_if.sv ====
interface cgt_clk_if (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce
);
   logic [1:0] src_sel;
   logic [2:0] div_code;
   logic       sel_level;
   logic       bus_clk;

   modport src (input clk, input rst, input ce, input src_sel,
                output sel_level);
   modport div (input clk, input rst, input ce, input div_code,
                input sel_level, output bus_clk);
endinterface : cgt_clk_if

// ==== cgt_src_select.sv ====
module cgt_src_select (
   cgt_clk_if.src   cif,
   input wire logic loop_clk,
   input wire logic int_ref_clk,
   input wire logic ext_ref_clk
);
   logic [2:0] meta;
   logic [2:0] sync;
   logic       sel_level;
   logic [2:0] next_meta;
   logic [2:0] next_sync;
   logic       next_sel_level;

   always_comb begin
      next_meta = {ext_ref_clk, int_ref_clk, loop_clk};
      next_sync = meta;
      unique case (cgt_pkg::cgt_src_t'(cif.src_sel))
         cgt_pkg::CGT_SRC_INT: next_sel_level = sync[1];
         cgt_pkg::CGT_SRC_EXT: next_sel_level = sync[2];
         default:              next_sel_level = sync[0];
      endcase
   end

   always_ff @(posedge cif.clk or posedge cif.rst) begin
      if (cif.rst) begin
         meta      <= 3'h0;
         sync      <= 3'h0;
         sel_level <= 1'h0;
      end else if (cif.ce) begin
         meta      <= next_meta;
         sync      <= next_sync;
         sel_level <= next_sel_level;
      end
   end

   assign cif.sel_level = sel_level;

endmodule : cgt_src_select

// ==== cgt_bus_divider.sv ====
module cgt_bus_divider (
   cgt_clk_if.div cif
);
   logic       prev;
   logic [6:0] count;
   logic [2:0] active;
   logic       bus_clk;
   logic       next_prev;
   logic [6:0] next_count;
   logic [2:0] next_active;
   logic       next_bus_clk;
   logic       tick;

   always_comb begin
      next_prev   = cif.sel_level;
      tick        = cif.sel_level & ~prev;
      next_count  = count;
      next_active = active;
      if (tick) begin
         next_count = count + 7'h01;
         // Ratio changes only at full wrap, so no runt phase
         if (count == cgt_pkg::DIV_COUNT_WRAP) begin
            next_active = cif.div_code;
         end
      end
      if (next_active == 3'h0) begin
         next_bus_clk = cif.sel_level;
      end else begin
         next_bus_clk = next_count[next_active - 3'h1];
      end
   end

   always_ff @(posedge cif.clk or posedge cif.rst) begin
      if (cif.rst) begin
         prev    <= 1'h0;
         count   <= 7'h00;
         active  <= cgt_pkg::DIV_RESET;
         bus_clk <= 1'h0;
      end else if (cif.ce) begin
         prev    <= next_prev;
         count   <= next_count;
         active  <= next_active;
         bus_clk <= next_bus_clk;
      end
   end

   assign cif.bus_clk = bus_clk;

   property p_ratio_at_wrap;
      @(posedge cif.clk) disable iff (cif.rst)
      (active != $past(active)) |-> (count == 7'h00);
   endproperty
   a_ratio_at_wrap: assert property (p_ratio_at_wrap)
      else $error("divider ratio changed away from counter wrap");

endmodule : cgt_bus_divider

// ==== cgt_top.sv ====
module cgt_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        LOOP_CLK_IN,
   input  wire logic        INT_REF_CLK_IN,
   input  wire logic        EXT_REF_CLK_IN,
   input  wire logic        DEBUG_ACTIVE,
   input  wire logic [7:0]  FACTORY_COARSE_TRIM,
   input  wire logic        FACTORY_FINE_TRIM,
   input  wire logic        LOSS_OF_LOCK_EVENT,
   input  wire logic        EXT_CLOCK_LOST,
   output logic             BUS_CLK,
   output logic             LOOP_POWER_DOWN,
   output logic      [7:0]  SLOW_REF_COARSE_TRIM,
   output logic             SLOW_REF_FINE_TRIM,
   output logic             LOSS_OF_LOCK_IRQ,
   output logic             CLOCK_MONITOR_RESET_REQ
);

   cgt_pkg::cgt_state_t state;
   cgt_pkg::cgt_state_t next_state;

   logic [1:0]  clock_source_select;
   logic [2:0]  bus_clock_divider;
   logic        bypass_loop_power_down;
   logic [7:0]  slow_ref_coarse_trim;
   logic        slow_ref_fine_trim;
   logic        loss_of_lock_irq_enable;
   logic        ext_clock_monitor_enable;
   logic        loss_of_lock_flag;
   logic        waitrequest;
   logic [31:0] readdata;
   logic        irq;
   logic        reset_req;
   logic        power_down;

   logic [1:0]  next_clock_source_select;
   logic [2:0]  next_bus_clock_divider;
   logic        next_bypass_loop_power_down;
   logic [7:0]  next_slow_ref_coarse_trim;
   logic        next_slow_ref_fine_trim;
   logic        next_loss_of_lock_irq_enable;
   logic        next_ext_clock_monitor_enable;
   logic        next_loss_of_lock_flag;
   logic        next_waitrequest;
   logic [31:0] next_readdata;
   logic        next_irq;
   logic        next_reset_req;
   logic        next_power_down;

   logic        request;
   logic        wr_en;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   logic        bypassed;

   cgt_clk_if u_clk_if (
      .clk (SYS_CLK),
      .rst (RST),
      .ce  (CE)
   );

   assign u_clk_if.src_sel  = clock_source_select;
   assign u_clk_if.div_code = bus_clock_divider;

   cgt_src_select u_src_select (
      .cif         (u_clk_if.src),
      .loop_clk    (LOOP_CLK_IN),
      .int_ref_clk (INT_REF_CLK_IN),
      .ext_ref_clk (EXT_REF_CLK_IN)
   );

   cgt_bus_divider u_bus_divider (
      .cif (u_clk_if.div)
   );

   // Bus slave: one wait cycle, then the answer
   always_comb begin
      request          = AVS_READ | AVS_WRITE;
      wr_en            = AVS_WRITE & ~waitrequest & AVS_BYTEENABLE[0];
      wbyte            = AVS_WRITEDATA[7:0];
      next_waitrequest = ~(request & waitrequest);
      rbyte            = 8'h00;
      if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_SRC_CTRL)) begin
         rbyte[cgt_pkg::SRC_SEL_LSB +: 2] = clock_source_select;
      end
      if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_DIV_CTRL)) begin
         rbyte[cgt_pkg::DIV_LSB +: 3]       = bus_clock_divider;
         rbyte[cgt_pkg::PWR_DOWN_BIT]       = bypass_loop_power_down;
      end
      if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_COARSE)) begin
         rbyte = slow_ref_coarse_trim;
      end
      if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_FINE_CTRL)) begin
         rbyte[cgt_pkg::LOL_IRQ_EN_BIT] = loss_of_lock_irq_enable;
         rbyte[cgt_pkg::MON_EN_BIT]     = ext_clock_monitor_enable;
         rbyte[cgt_pkg::FINE_TRIM_BIT]  = slow_ref_fine_trim;
      end
      if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_STATUS)) begin
         rbyte[cgt_pkg::LOL_FLAG_BIT] = loss_of_lock_flag;
      end
      next_readdata = readdata;
      if (AVS_READ && waitrequest) begin
         next_readdata = {24'h000000, rbyte};
      end
   end

   // Register file and trim load
   always_comb begin
      next_state                    = state;
      next_clock_source_select      = clock_source_select;
      next_bus_clock_divider        = bus_clock_divider;
      next_bypass_loop_power_down   = bypass_loop_power_down;
      next_slow_ref_coarse_trim     = slow_ref_coarse_trim;
      next_slow_ref_fine_trim       = slow_ref_fine_trim;
      next_loss_of_lock_irq_enable  = loss_of_lock_irq_enable;
      next_ext_clock_monitor_enable = ext_clock_monitor_enable;
      next_loss_of_lock_flag        = loss_of_lock_flag;
      unique case (state)
         cgt_pkg::CGT_ST_LOAD: begin
            // Strap-style capture just after release, not under reset
            if (!DEBUG_ACTIVE) begin
               next_slow_ref_coarse_trim = FACTORY_COARSE_TRIM;
               next_slow_ref_fine_trim   = FACTORY_FINE_TRIM;
            end
            next_state = cgt_pkg::CGT_ST_RUN;
         end
         cgt_pkg::CGT_ST_RUN: begin
            next_state = cgt_pkg::CGT_ST_RUN;
         end
         default: begin
            next_state = cgt_pkg::CGT_ST_RUN;
         end
      endcase
      if (wr_en) begin
         if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_SRC_CTRL)) begin
            next_clock_source_select = wbyte[cgt_pkg::SRC_SEL_LSB +: 2];
         end
         if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_DIV_CTRL)) begin
            next_bus_clock_divider = wbyte[cgt_pkg::DIV_LSB +: 3];
            next_bypass_loop_power_down = wbyte[cgt_pkg::PWR_DOWN_BIT];
         end
         if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_COARSE)) begin
            // Trim code passed as is; analog weighting is binary
            next_slow_ref_coarse_trim = wbyte;
         end
         if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_FINE_CTRL)) begin
            next_loss_of_lock_irq_enable  = wbyte[cgt_pkg::LOL_IRQ_EN_BIT];
            next_ext_clock_monitor_enable = wbyte[cgt_pkg::MON_EN_BIT];
            next_slow_ref_fine_trim = wbyte[cgt_pkg::FINE_TRIM_BIT];
         end
         if (cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_STATUS) &&
             wbyte[cgt_pkg::LOL_FLAG_BIT]) begin
            next_loss_of_lock_flag = 1'h0;
         end
      end
      // Set after clear, so a drift in the clearing cycle survives
      if (LOSS_OF_LOCK_EVENT) begin
         next_loss_of_lock_flag = 1'h1;
      end
   end

   // Outputs to the loop, interrupt and reset logic
   always_comb begin
      bypassed = (clock_source_select == cgt_pkg::CGT_SRC_INT) ||
                 (clock_source_select == cgt_pkg::CGT_SRC_EXT);
      next_power_down = bypass_loop_power_down & bypassed &
                        ~DEBUG_ACTIVE;
      next_irq        = loss_of_lock_flag &
                        loss_of_lock_irq_enable;
      // Mode legality is left to software; no gating by source here
      next_reset_req  = ext_clock_monitor_enable &
                        EXT_CLOCK_LOST;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state                    <= cgt_pkg::CGT_ST_LOAD;
         clock_source_select      <= cgt_pkg::CGT_SRC_LOOP;
         bus_clock_divider        <= cgt_pkg::DIV_RESET;
         bypass_loop_power_down   <= 1'h0;
         slow_ref_coarse_trim     <= cgt_pkg::COARSE_RESET;
         slow_ref_fine_trim       <= cgt_pkg::FINE_RESET;
         loss_of_lock_irq_enable  <= 1'h0;
         ext_clock_monitor_enable <= 1'h0;
         loss_of_lock_flag        <= 1'h0;
         waitrequest              <= 1'h1;
         readdata                 <= 32'h00000000;
         irq                      <= 1'h0;
         reset_req                <= 1'h0;
         power_down               <= 1'h0;
      end else if (CE) begin
         state                    <= next_state;
         clock_source_select      <= next_clock_source_select;
         bus_clock_divider        <= next_bus_clock_divider;
         bypass_loop_power_down   <= next_bypass_loop_power_down;
         slow_ref_coarse_trim     <= next_slow_ref_coarse_trim;
         slow_ref_fine_trim       <= next_slow_ref_fine_trim;
         loss_of_lock_irq_enable  <= next_loss_of_lock_irq_enable;
         ext_clock_monitor_enable <= next_ext_clock_monitor_enable;
         loss_of_lock_flag        <= next_loss_of_lock_flag;
         waitrequest              <= next_waitrequest;
         readdata                 <= next_readdata;
         irq                      <= next_irq;
         reset_req                <= next_reset_req;
         power_down               <= next_power_down;
      end
   end

   assign AVS_READDATA            = readdata;
   assign AVS_WAITREQUEST         = waitrequest;
   assign BUS_CLK                 = u_clk_if.bus_clk;
   assign LOOP_POWER_DOWN         = power_down;
   assign SLOW_REF_COARSE_TRIM    = slow_ref_coarse_trim;
   assign SLOW_REF_FINE_TRIM      = slow_ref_fine_trim;
   assign LOSS_OF_LOCK_IRQ        = irq;
   assign CLOCK_MONITOR_RESET_REQ = reset_req;

   default clocking cgt_cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   sequence s_div_write;
      CE && wr_en && cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_DIV_CTRL);
   endsequence

   sequence s_status_keep;
      CE && wr_en && cgt_pkg::cgt_hit(AVS_ADDRESS, cgt_pkg::IDX_STATUS) &&
      !wbyte[cgt_pkg::LOL_FLAG_BIT];
   endsequence

   property p_div_reset;
      $past(RST) |-> (bus_clock_divider == 3'h1);
   endproperty
   a_div_reset: assert property (p_div_reset)
      else $error("divider code not 001 after reset");

   property p_div_write;
      s_div_write |=> (bus_clock_divider == $past(AVS_WRITEDATA[7:5]));
   endproperty
   a_div_write: assert property (p_div_write)
      else $error("divider code not taken from write");

   property p_lol_set;
      (CE && LOSS_OF_LOCK_EVENT) |=> loss_of_lock_flag;
   endproperty
   a_lol_set: assert property (p_lol_set)
      else $error("loss-of-lock flag missed an event");

   property p_lol_zero_write;
      (s_status_keep and loss_of_lock_flag) |=> loss_of_lock_flag;
   endproperty
   a_lol_zero_write: assert property (p_lol_zero_write)
      else $error("writing zero cleared loss-of-lock flag");

   property p_irq_follows;
      (CE && loss_of_lock_flag && loss_of_lock_irq_enable) |=>
         LOSS_OF_LOCK_IRQ;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("interrupt missing while flag and enable set");

   property p_irq_masked;
      (CE && !loss_of_lock_irq_enable) |=> !LOSS_OF_LOCK_IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt raised while disabled");

   property p_reset_req;
      CE |=> (CLOCK_MONITOR_RESET_REQ ==
              $past(ext_clock_monitor_enable && EXT_CLOCK_LOST));
   endproperty
   a_reset_req: assert property (p_reset_req)
      else $error("clock monitor reset request wrong");

   property p_power_down;
      (CE && (clock_source_select == 2'h3)) |=> !LOOP_POWER_DOWN;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("loop powered down while not bypassed");

   property p_reserved_zero;
      (!AVS_WAITREQUEST && AVS_READ) |-> (AVS_READDATA[31:8] == 24'h000000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved read data not zero");

   property p_trim_load;
      (CE && state == cgt_pkg::CGT_ST_LOAD && !DEBUG_ACTIVE) |=>
         (SLOW_REF_COARSE_TRIM == $past(FACTORY_COARSE_TRIM)) &&
         (SLOW_REF_FINE_TRIM == $past(FACTORY_FINE_TRIM));
   endproperty
   a_trim_load: assert property (p_trim_load)
      else $error("factory trim not loaded after reset");

   property p_wait_answer;
      (CE && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=>
         !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endproperty
   a_wait_answer: assert property (p_wait_answer)
      else $error("bus answer not one cycle after request");

endmodule : cgt_top

// ==== tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic        SYS_CLK = 1'b0;
   logic        RST = 1'b1;
   logic        CE = 1'b1;
   logic [4:0]  AVS_ADDRESS = 5'h00;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0]  AVS_BYTEENABLE = 4'h1;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic        LOOP_CLK_IN = 1'b0;
   logic        INT_REF_CLK_IN = 1'b0;
   logic        EXT_REF_CLK_IN = 1'b0;
   logic        DEBUG_ACTIVE = 1'b0;
   logic [7:0]  FACTORY_COARSE_TRIM = 8'h00;
   logic        FACTORY_FINE_TRIM = 1'b0;
   logic        LOSS_OF_LOCK_EVENT = 1'b0;
   logic        EXT_CLOCK_LOST = 1'b0;
   logic        BUS_CLK;
   logic        LOOP_POWER_DOWN;
   logic [7:0]  SLOW_REF_COARSE_TRIM;
   logic        SLOW_REF_FINE_TRIM;
   logic        LOSS_OF_LOCK_IRQ;
   logic        CLOCK_MONITOR_RESET_REQ;

   int          err_total = 0;
   int          checks_done = 0;
   int          seed = 32'hD394F104;
   logic [7:0]  exp_q[$];
   logic [3:0]  ph_loop = 4'h0;
   logic [3:0]  ph_int = 4'h0;
   logic [3:0]  ph_ext = 4'h0;
   int          cyc = 0;
   int          last_rise = 0;
   int          bus_per = 0;
   int          rises = 0;
   logic        bclk_d = 1'b0;

   always #50 SYS_CLK = ~SYS_CLK;

   cgt_top dut (
      .SYS_CLK                 (SYS_CLK),
      .RST                     (RST),
      .CE                      (CE),
      .AVS_ADDRESS             (AVS_ADDRESS),
      .AVS_READ                (AVS_READ),
      .AVS_WRITE               (AVS_WRITE),
      .AVS_WRITEDATA           (AVS_WRITEDATA),
      .AVS_BYTEENABLE          (AVS_BYTEENABLE),
      .AVS_READDATA            (AVS_READDATA),
      .AVS_WAITREQUEST         (AVS_WAITREQUEST),
      .LOOP_CLK_IN             (LOOP_CLK_IN),
      .INT_REF_CLK_IN          (INT_REF_CLK_IN),
      .EXT_REF_CLK_IN          (EXT_REF_CLK_IN),
      .DEBUG_ACTIVE            (DEBUG_ACTIVE),
      .FACTORY_COARSE_TRIM     (FACTORY_COARSE_TRIM),
      .FACTORY_FINE_TRIM       (FACTORY_FINE_TRIM),
      .LOSS_OF_LOCK_EVENT      (LOSS_OF_LOCK_EVENT),
      .EXT_CLOCK_LOST          (EXT_CLOCK_LOST),
      .BUS_CLK                 (BUS_CLK),
      .LOOP_POWER_DOWN         (LOOP_POWER_DOWN),
      .SLOW_REF_COARSE_TRIM    (SLOW_REF_COARSE_TRIM),
      .SLOW_REF_FINE_TRIM      (SLOW_REF_FINE_TRIM),
      .LOSS_OF_LOCK_IRQ        (LOSS_OF_LOCK_IRQ),
      .CLOCK_MONITOR_RESET_REQ (CLOCK_MONITOR_RESET_REQ)
   );

   // Source clocks: periods 12, 8 and 10 cycles, well below half rate
   always @(posedge SYS_CLK) begin
      ph_loop <= (ph_loop == 4'h5) ? 4'h0 : ph_loop + 4'h1;
      ph_int  <= (ph_int == 4'h3) ? 4'h0 : ph_int + 4'h1;
      ph_ext  <= (ph_ext == 4'h4) ? 4'h0 : ph_ext + 4'h1;
      if (ph_loop == 4'h5) LOOP_CLK_IN <= ~LOOP_CLK_IN;
      if (ph_int == 4'h3) INT_REF_CLK_IN <= ~INT_REF_CLK_IN;
      if (ph_ext == 4'h4) EXT_REF_CLK_IN <= ~EXT_REF_CLK_IN;
   end

   // Period of the bus clock, in system cycles between rising edges
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      bclk_d <= BUS_CLK;
      if (BUS_CLK === 1'b1 && bclk_d === 1'b0) begin
         bus_per <= cyc - last_rise;
         last_rise <= cyc;
         rises <= rises + 1;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // Read answers are compared in order against the driver's notes
   always @(posedge SYS_CLK) begin
      if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
         if (exp_q.size() == 0) chk(AVS_READDATA, 32'hFFFFFFFF, "no note");
         else chk(AVS_READDATA, {24'h0, exp_q.pop_front()}, "read data");
      end
   end

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [7:0] d, input logic [3:0] be,
                      input logic [7:0] exp);
      int n;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_BYTEENABLE <= be;
      if (wr) AVS_WRITE <= 1'b1;
      else begin
         AVS_READ <= 1'b1;
         exp_q.push_back(exp);
      end
      n = 0;
      // No cycle limit here; a hang is left to the watchdog
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0);
      chk(32'(n), 32'h2, "bus answer latency");
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, 8'h00);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hF, exp);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask : idle

   task automatic do_reset(input logic dbg);
      @(posedge SYS_CLK);
      RST <= 1'b1;
      DEBUG_ACTIVE <= dbg;
      idle(20);
      RST <= 1'b0;
      idle(2);
      DEBUG_ACTIVE <= 1'b0;
   endtask : do_reset

   // Sampled on the falling edge so the period register has settled
   task automatic per(input int exp);
      int r0;
      int k;
      idle(1700);
      r0 = rises;
      for (k = 0; k < 5000 && rises < r0 + 2; k++) @(negedge SYS_CLK);
      chk(32'(bus_per), 32'(exp), "bus clock period");
   endtask : per

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   initial begin
      #4000000;
      err_total++;
      print_verdict();
   end

   initial begin
      logic [7:0] mask [5];
      logic [7:0] d;
      int         p [4];
      mask = '{8'h80, 8'hF0, 8'hFF, 8'hA1, 8'h00};
      p = '{12, 8, 10, 12};
      FACTORY_COARSE_TRIM = 8'($random(seed));
      FACTORY_FINE_TRIM = 1'b1;
      do_reset(1'b0);
      rd(5'h00, 8'h00);
      rd(5'h04, 8'h20);
      rd(5'h08, FACTORY_COARSE_TRIM);
      rd(5'h0C, 8'h01);
      rd(5'h10, 8'h00);
      chk(SLOW_REF_COARSE_TRIM, FACTORY_COARSE_TRIM, "coarse out");
      for (int i = 0; i < 5; i++) begin
         // Source left external before the monitor enable is set
         wr(5'(i * 4), (i == 0) ? 8'hBF : 8'hFF);
         rd(5'(i * 4), mask[i]);
      end
      rd(5'h14, 8'h00);
      rd(5'h09, 8'h00);
      wr(5'h0A, 8'h12);
      bus(1'b1, 5'h08, 8'h34, 4'hE, 8'h00);
      rd(5'h08, 8'hFF);
      d = 8'($random(seed));
      wr(5'h08, d);
      rd(5'h08, d);
      idle(2);
      chk(SLOW_REF_COARSE_TRIM, d, "coarse trim out");
      for (int f = 0; f < 2; f++) begin
         wr(5'h0C, 8'(f));
         idle(2);
         chk(SLOW_REF_FINE_TRIM, 32'(f), "fine trim out");
      end
      for (int pd = 0; pd < 2; pd++)
         for (int s = 0; s < 4; s++)
            for (int g = 0; g < 2; g++) begin
               wr(5'h04, pd ? 8'h30 : 8'h20);
               wr(5'h00, 8'(s << 6));
               @(posedge SYS_CLK);
               DEBUG_ACTIVE <= g[0];
               idle(3);
               chk(LOOP_POWER_DOWN,
                   32'(pd && (s == 1 || s == 2) && !g), "power down");
            end
      @(posedge SYS_CLK);
      DEBUG_ACTIVE <= 1'b0;
      for (int e = 1; e >= 0; e--) begin
         wr(5'h0C, e ? 8'h80 : 8'h00);
         @(posedge SYS_CLK);
         LOSS_OF_LOCK_EVENT <= 1'b1;
         @(posedge SYS_CLK);
         LOSS_OF_LOCK_EVENT <= 1'b0;
         idle(3);
         chk(LOSS_OF_LOCK_IRQ, 32'(e), "irq level");
         wr(5'h10, 8'h00);
         rd(5'h10, 8'h80);
         wr(5'h10, 8'h80);
         rd(5'h10, 8'h00);
         idle(2);
         chk(LOSS_OF_LOCK_IRQ, 32'h0, "irq after clear");
      end
      // Clock enable low must freeze the flag against events
      @(posedge SYS_CLK);
      CE <= 1'b0;
      LOSS_OF_LOCK_EVENT <= 1'b1;
      idle(3);
      CE <= 1'b1;
      LOSS_OF_LOCK_EVENT <= 1'b0;
      rd(5'h10, 8'h00);
      wr(5'h00, 8'h80);
      for (int m = 0; m < 2; m++) begin
         wr(5'h0C, m ? 8'h20 : 8'h00);
         @(posedge SYS_CLK);
         EXT_CLOCK_LOST <= 1'b1;
         idle(3);
         chk(CLOCK_MONITOR_RESET_REQ, 32'(m), "monitor reset");
         EXT_CLOCK_LOST <= 1'b0;
         idle(3);
         chk(CLOCK_MONITOR_RESET_REQ, 32'h0, "monitor idle");
      end
      wr(5'h04, 8'h20);
      for (int s = 0; s < 4; s++) begin
         wr(5'h00, 8'(s << 6));
         per(2 * p[s]);
      end
      wr(5'h00, 8'h40);
      for (int c = 0; c < 8; c++) begin
         wr(5'h04, 8'(c << 5));
         per(8 << c);
      end
      do_reset(1'b1);
      rd(5'h08, 8'h00);
      rd(5'h0C, 8'h00);
      print_verdict();
   end

endmodule : tb_top
